//--- rtl/bix_pkg.sv
`default_nettype none
package bix_pkg;
  localparam int INSN_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 13;
  localparam int LIT_W = 11;
  localparam logic [5:0] OP_INCREMENT_FILE = 6'h0A;
  localparam logic [2:0] OP_JUMP_ABSOLUTE = 3'h5;
  localparam int OP6_HI = 13;
  localparam int OP6_LO = 8;
  localparam int OP3_LO = 11;
  localparam int DEST_BIT = 7;
  localparam int LATCH_PAGE_HI = 4;
  localparam int LATCH_PAGE_LO = 3;
  localparam logic DEST_WORKING = 1'b0;
  localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic [INSN_W-1:0] INSN_NOP = 14'h0000;
  typedef enum logic [1:0] {
    BIX_EXEC,
    BIX_FLUSH
  } bix_state_type;
endpackage
`default_nettype wire

//--- rtl/bix_decode.sv
`timescale 1ns/1ps
`default_nettype none
module bix_decode (
  input  wire logic [13:0] insn,
  output logic             is_increment,
  output logic             is_jump,
  output logic             dest_file,
  output logic [6:0]       file_addr,
  output logic [10:0]      literal
);
  // opcode recognition and field extraction
  always_comb begin
    is_increment = insn[bix_pkg::OP6_HI:bix_pkg::OP6_LO]
                   == bix_pkg::OP_INCREMENT_FILE;
    is_jump = insn[bix_pkg::OP6_HI:bix_pkg::OP3_LO]
              == bix_pkg::OP_JUMP_ABSOLUTE;
    dest_file = insn[bix_pkg::DEST_BIT];
    file_addr = insn[bix_pkg::FADDR_W-1:0];
    literal = insn[bix_pkg::LIT_W-1:0];
  end
endmodule
`default_nettype wire

//--- rtl/bix_exec.sv
`timescale 1ns/1ps
`default_nettype none
module bix_exec (
  input  wire logic        CLOCK,
  input  wire logic        RESETN,
  input  wire logic        INSN_VALID,
  input  wire logic [13:0] INSN,
  input  wire logic [7:0]  FILE_RDATA,
  input  wire logic [7:0]  PC_HIGH_LATCH,
  output logic [6:0]       FILE_ADDR,
  output logic             FILE_WE,
  output logic [7:0]       FILE_WDATA,
  output logic             W_WE,
  output logic [7:0]       W_WDATA,
  output logic             ZERO_WE,
  output logic             ZERO_FLAG,
  output logic             PC_LOAD,
  output logic [12:0]      PC_VALUE,
  output logic             FLUSH,
  output logic             BUSY
);
  logic        is_increment;
  logic        is_jump;
  logic        dest_file;
  logic [6:0]  file_addr;
  logic [10:0] literal;
  logic [7:0]  sum;
  logic        accept;
  bix_pkg::bix_state_type state_q;
  bix_pkg::bix_state_type state_d;

  bix_decode u_decode (
    .insn         (INSN),
    .is_increment (is_increment),
    .is_jump      (is_jump),
    .dest_file    (dest_file),
    .file_addr    (file_addr),
    .literal      (literal)
  );

  // file address is combinational toward the register file read port
  assign FILE_ADDR = file_addr;
  assign sum = FILE_RDATA + bix_pkg::DATA_ONE;
  assign accept = INSN_VALID && (state_q == bix_pkg::BIX_EXEC);

  // sequencing: jump inserts one no-operation cycle
  always_comb begin
    state_d = state_q;
    case (state_q)
      bix_pkg::BIX_EXEC: begin
        if (accept && is_jump) begin
          state_d = bix_pkg::BIX_FLUSH;
        end
      end
      bix_pkg::BIX_FLUSH: begin
        state_d = bix_pkg::BIX_EXEC;
      end
      default: begin
        state_d = bix_pkg::BIX_EXEC;
      end
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= bix_pkg::BIX_EXEC;
    end else begin
      state_q <= state_d;
    end
  end

  // increment result routing, single cycle
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      FILE_WE    <= 1'b0;
      FILE_WDATA <= bix_pkg::DATA_ZERO;
      W_WE       <= 1'b0;
      W_WDATA    <= bix_pkg::DATA_ZERO;
      ZERO_WE    <= 1'b0;
      ZERO_FLAG  <= 1'b0;
    end else begin
      FILE_WE <= accept && is_increment && dest_file;
      W_WE    <= accept && is_increment
                 && (dest_file == bix_pkg::DEST_WORKING);
      ZERO_WE <= accept && is_increment;
      if (accept && is_increment) begin
        FILE_WDATA <= sum;
        W_WDATA    <= sum;
        ZERO_FLAG  <= (sum == bix_pkg::DATA_ZERO);
      end
    end
  end

  // jump: pc load with page bits, flags untouched
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      PC_LOAD  <= 1'b0;
      PC_VALUE <= bix_pkg::PC_RESET;
      FLUSH    <= 1'b0;
      BUSY     <= 1'b0;
    end else begin
      PC_LOAD <= accept && is_jump;
      FLUSH   <= accept && is_jump;
      BUSY    <= (state_d == bix_pkg::BIX_FLUSH);
      if (accept && is_jump) begin
        PC_VALUE <= {PC_HIGH_LATCH[bix_pkg::LATCH_PAGE_HI:
                                   bix_pkg::LATCH_PAGE_LO],
                     literal};
      end
    end
  end
endmodule
`default_nettype wire

//--- verif/bix_exec_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bix_exec_chk (
  input wire logic        CLOCK,
  input wire logic        RESETN,
  input wire logic        INSN_VALID,
  input wire logic [13:0] INSN,
  input wire logic [7:0]  FILE_RDATA,
  input wire logic [7:0]  PC_HIGH_LATCH,
  input wire logic [6:0]  FILE_ADDR,
  input wire logic        FILE_WE,
  input wire logic [7:0]  FILE_WDATA,
  input wire logic        W_WE,
  input wire logic [7:0]  W_WDATA,
  input wire logic        FLUSH,
  input wire logic        ZERO_WE,
  input wire logic        ZERO_FLAG,
  input wire logic        PC_LOAD,
  input wire logic [12:0] PC_VALUE,
  input wire logic        BUSY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  wire logic inc = INSN_VALID && !BUSY && INSN[13:8] == 6'h0A;
  wire logic jmp = INSN_VALID && !BUSY && INSN[13:11] == 3'h5;
  chk_inc_value: assert property (inc |=> ZERO_WE &&
    FILE_WDATA == 8'($past(FILE_RDATA) + 8'h01) &&
    ZERO_FLAG == ($past(FILE_RDATA) == 8'hFF)) else $error("bad increment");
  chk_wdata_value: assert property (inc |=>
    W_WDATA == 8'($past(FILE_RDATA) + 8'h01)) else $error("bad w data");
  chk_addr_pass: assert property (FILE_ADDR == INSN[6:0])
    else $error("bad file address");
  chk_flush_pulse: assert property (FLUSH == $past(jmp))
    else $error("bad flush");
  chk_dest_steer: assert property (inc |=>
    FILE_WE == $past(INSN[7]) && W_WE != $past(INSN[7]))
    else $error("bad destination");
  chk_other_idle: assert property (!inc |=> !FILE_WE && !W_WE)
    else $error("write without increment");
  chk_jump_load: assert property (jmp |=> PC_LOAD && BUSY &&
    PC_VALUE == {$past(PC_HIGH_LATCH[4:3]), $past(INSN[10:0])})
    else $error("bad jump");
  chk_jump_nop: assert property (PC_LOAD |-> !ZERO_WE ##1
    !PC_LOAD && !BUSY && !W_WE && !FILE_WE) else $error("bad no-op");
endmodule
bind bix_exec bix_exec_chk u_bix_exec_chk (.*);
`default_nettype wire

//--- verif/test_branch_and_increment_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_branch_and_increment_exec;
  logic clock = 0, resetn = 0, valid = 0, eb = 0, ai, aj;
  logic [13:0] insn = 0;
  logic [7:0] rd = 0, lat = 0;
  wire logic fwe, wwe, zwe, zf, pcl, busy, fl;
  wire logic [6:0] fad;
  wire logic [7:0] fwd, wwd;
  wire logic [12:0] pcv;
  int fail_count = 0, check_count = 0, k;
  bix_exec u_bix_exec (.CLOCK(clock), .RESETN(resetn), .INSN_VALID(valid),
    .INSN(insn), .FILE_RDATA(rd), .PC_HIGH_LATCH(lat), .FILE_ADDR(fad),
    .FILE_WE(fwe), .FILE_WDATA(fwd), .W_WE(wwe), .W_WDATA(wwd),
    .ZERO_WE(zwe), .ZERO_FLAG(zf), .PC_LOAD(pcl), .PC_VALUE(pcv),
    .FLUSH(fl), .BUSY(busy));
  task chk(string n, logic [15:0] x, logic [15:0] g);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask
  task final_report;
    $display("checks %0d errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial forever #4 clock = ~clock;
  initial begin
    k = $urandom(94);
    repeat (10) @(negedge clock);
    resetn = 1;
    repeat (400) begin
      k = $urandom % 4;
      valid = $urandom % 4 != 0;
      rd = k == 3 ? 8'hFF : 8'($urandom);
      lat = 8'($urandom);
      insn = k == 1 ? {3'h5, 11'($urandom)} :
             {k == 2 ? 6'h03 : 6'h0A, 8'($urandom)};
      ai = valid && !eb && (k == 0 || k == 3);
      aj = valid && !eb && k == 1;
      @(negedge clock);
      chk("file_we", ai && insn[7], fwe);
      chk("w_we", ai && !insn[7], wwe);
      chk("zero_we", ai, zwe);
      chk("pc_load", aj, pcl);
      chk("busy", aj, busy);
      chk("flush", aj, fl);
      chk("file_addr", insn[6:0], fad);
      if (ai) chk("w_result", 8'(rd + 8'h01), wwd);
      if (ai) chk("f_result", 8'(rd + 8'h01), fwd);
      if (ai) chk("result", 8'(rd + 8'h01), insn[7] ? fwd : wwd);
      if (ai) chk("zero", rd == 8'hFF, zf);
      if (aj) chk("pc", {lat[4:3], insn[10:0]}, pcv);
      eb = aj;
    end
    final_report();
  end
endmodule
`default_nettype wire
